// *** stt_pkg.sv ***
// constants and state type for the tlb and timer system-control registers
// Functional notes
// - random writes never target pinned tlb entries unless the boundary exceeds 47
// - pinned boundary clears to zero on reset
// - pinned write reloads victim index to top
// - boundary in 5:0, upper bits read zero
// - fault address captures vaddr of the latest exception, tlb or not
// - no fault capture while exception level set
// - fault address is 32 or 64 bits wide
// - counter steps once every two core clocks
// - counter 32 bits, resets zero, software writable
// - entry high is source or destination for tlb ops
// - tlb exceptions load page pair and space id
// - space id in 7:0, bits 12:8 read zero
// - wide mode region code in bits 63:62
// - wide mode bits 61:40 zero, page pair 39:13
// - counter equal to match value sets pending bit 7
// - pending timer interrupt taken once enabled and masked in
// - match value write clears timer pending unless counter equals match that cycle
// - match value 32 bits, resets zero, stable
// - take only when enabled, masked and pending
// - kernel wide flag selects 64-bit layouts
package stt_pkg;
  // register numbers as the move-to/move-from instructions name them
  localparam logic [4:0] REG_PINNED = 5'h06;
  localparam logic [4:0] REG_FAULT = 5'h08;
  localparam logic [4:0] REG_COUNT = 5'h09;
  localparam logic [4:0] REG_EHI = 5'h0a;
  localparam logic [4:0] REG_MATCH = 5'h0b;
  // tlb geometry; highest entry index is the victim upper bound
  localparam logic [5:0] TLB_TOP = 6'h2f;
  localparam int PINNED_W = 6;
  // entry high layouts: writable bits in each mode
  localparam logic [63:0] EHI_MASK_64 = 64'hc000_00ff_ffff_e0ff;
  localparam logic [63:0] EHI_MASK_32 = 64'h0000_0000_ffff_e0ff;
  localparam int EHI_ZERO_HI = 12;
  localparam int EHI_ZERO_LO = 8;
  localparam int TIMER_IRQ_BIT = 7;
  // reset values
  localparam logic [5:0] PINNED_RST = 6'h00;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
  // whole register state of the block
  typedef struct packed {
    logic [5:0] pinned;
    logic [5:0] victim;
    logic [63:0] fault;
    logic [31:0] count;
    logic half;
    logic [63:0] ehi;
    logic [31:0] match;
    logic [7:0] pend;
    logic take;
    logic [63:0] rd_data;
    logic rd_valid;
    logic [5:0] wr_idx;
  } stt_state_type;
  localparam stt_state_type STATE_RST = '{
    pinned: PINNED_RST, victim: TLB_TOP, count: COUNT_RST, match: MATCH_RST, default: '0};
endpackage : stt_pkg

// *** stt_regs.sv ***
// tlb pinned boundary, fault address, entry high, counter and match registers
`timescale 1ns/1ps
module stt_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  // instruction side register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [4:0] reg_num,
  input wire logic [63:0] reg_wr_data,
  output logic [63:0] reg_rd_data,
  output logic reg_rd_valid,
  // status register fields supplied by the core
  input wire logic exception_level_flag,
  input wire logic kernel_wide_addr,
  input wire logic irq_global_enable,
  input wire logic [7:0] irq_mask_field,
  input wire logic [6:0] irq_other_pending,
  // exception reporting from the pipeline
  input wire logic exc_valid,
  input wire logic exc_is_tlb,
  input wire logic [63:0] exc_vaddr,
  input wire logic [7:0] exc_space_id,
  // tlb operations
  input wire logic tlb_probe_op,
  input wire logic tlb_write_rand_op,
  input wire logic tlb_write_idx_op,
  input wire logic tlb_read_idx_op,
  input wire logic [63:0] tlb_read_entry_high,
  output logic [63:0] tlb_entry_high,
  output logic [5:0] tlb_victim_index,
  output logic [5:0] tlb_write_index,
  // interrupt side
  output logic [7:0] irq_pending_field,
  output logic irq_take
);
  import stt_pkg::*;

  stt_state_type s_q; // registered state
  stt_state_type s_d; // next state
  logic match_hit; // counter equals match value
  logic [63:0] ehi_mask; // writable entry high bits in current mode
  logic [63:0] rd_mux; // read data before registering
  logic wr_pinned; // decoded writes
  logic wr_count;
  logic wr_ehi;
  logic wr_match;

  // decode of the software write port
  assign wr_pinned = reg_wr_en && (reg_num == REG_PINNED);
  assign wr_count = reg_wr_en && (reg_num == REG_COUNT);
  assign wr_ehi = reg_wr_en && (reg_num == REG_EHI);
  assign wr_match = reg_wr_en && (reg_num == REG_MATCH);
  assign match_hit = (s_q.count == s_q.match);
  // layout chosen by the kernel wide flag
  assign ehi_mask = kernel_wide_addr ? EHI_MASK_64 : EHI_MASK_32;

  // read multiplexer; 32-bit mode shows sign-extended low words of fault and entry high
  always_comb begin
    rd_mux = 64'h0000_0000_0000_0000;
    unique case (reg_num)
      REG_PINNED: begin
        rd_mux = {58'h0, s_q.pinned};
      end
      REG_FAULT: begin
        if (kernel_wide_addr) begin
          rd_mux = s_q.fault;
        end else begin
          rd_mux = {{32{s_q.fault[31]}}, s_q.fault[31:0]};
        end
      end
      REG_COUNT: begin
        rd_mux = {32'h0, s_q.count};
      end
      REG_EHI: begin
        if (kernel_wide_addr) begin
          rd_mux = s_q.ehi & EHI_MASK_64;
        end else begin
          rd_mux = {{32{s_q.ehi[31]}}, s_q.ehi[31:0] & EHI_MASK_32[31:0]};
        end
      end
      REG_MATCH: begin
        rd_mux = {32'h0, s_q.match};
      end
      default: begin
        rd_mux = 64'h0000_0000_0000_0000; // unmapped numbers read zero
      end
    endcase
  end

  // next-state logic for every register of the block
  always_comb begin
    s_d = s_q;
    // read port answers one cycle after the request
    s_d.rd_valid = reg_rd_en;
    s_d.rd_data = reg_rd_en ? rd_mux : 64'h0000_0000_0000_0000;

    // pinned boundary; only 5:0 stored, upper bits dropped
    if (wr_pinned) begin
      s_d.pinned = reg_wr_data[PINNED_W-1:0];
    end

    // victim index counts down each cycle to the boundary, or sits at 47 when the boundary exceeds 47
    if (wr_pinned) begin
      s_d.victim = TLB_TOP;
    end else if (s_q.victim <= s_q.pinned || s_q.victim > TLB_TOP) begin
      s_d.victim = TLB_TOP;
    end else begin
      s_d.victim = s_q.victim - 6'h01;
    end

    // index used by the last random tlb write; random writes take the victim
    if (tlb_write_rand_op) begin
      s_d.wr_idx = (s_q.victim < s_q.pinned) ? TLB_TOP : s_q.victim;
    end

    // fault address: frozen while a handler already runs
    if (exc_valid && !exception_level_flag) begin
      s_d.fault = exc_vaddr;
    end

    // counter: half-rate step, wraps from all ones to zero
    s_d.half = ~s_q.half;
    if (wr_count) begin
      s_d.count = reg_wr_data[31:0];
    end else if (s_q.half) begin
      s_d.count = s_q.count + COUNT_STEP;
    end

    // entry high: exception beats tlb read beats software write
    if (exc_valid && exc_is_tlb) begin
      s_d.ehi = (exc_vaddr & ehi_mask & ~64'hff) | {56'h0, exc_space_id};
    end else if (tlb_read_idx_op) begin
      s_d.ehi = tlb_read_entry_high & ehi_mask;
    end else if (wr_ehi) begin
      s_d.ehi = reg_wr_data & ehi_mask;
    end

    // match value changes only by software write
    if (wr_match) begin
      s_d.match = reg_wr_data[31:0];
    end

    // timer pending: a match in the write cycle still wins
    s_d.pend[TIMER_IRQ_BIT] = match_hit || (s_q.pend[TIMER_IRQ_BIT] && !wr_match);
    s_d.pend[6:0] = irq_other_pending;

    // interrupt request once enabled, masked in and pending
    s_d.take = irq_global_enable && |(irq_mask_field & s_q.pend);
  end

  // one register stage for the whole state; reset to constants only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign reg_rd_data = s_q.rd_data;
  assign reg_rd_valid = s_q.rd_valid;
  assign tlb_entry_high = s_q.ehi;
  assign tlb_victim_index = s_q.victim;
  assign tlb_write_index = s_q.wr_idx;
  assign irq_pending_field = s_q.pend;
  assign irq_take = s_q.take;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // victim index never falls below the boundary when room exists
  victim_floor_a: assert property (s_q.pinned <= TLB_TOP |-> ##1
    (s_q.victim >= $past(s_q.pinned) || s_q.victim == TLB_TOP))
    else $error("victim index below pinned boundary");
  // random write index respects the boundary
  rand_index_a: assert property (tlb_write_rand_op && s_q.pinned <= TLB_TOP |=>
    tlb_write_index >= $past(s_q.pinned))
    else $error("random write hit a pinned entry");
  // boundary write reloads the victim index
  pinned_reload_a: assert property (wr_pinned |=> tlb_victim_index == TLB_TOP)
    else $error("victim not reloaded on boundary write");
  // upper boundary bits read zero
  pinned_read_a: assert property (reg_rd_en && reg_num == REG_PINNED |=>
    reg_rd_valid && reg_rd_data[63:6] == 58'h0)
    else $error("boundary reserved bits not zero");
  // fault capture outside exception level
  fault_capture_a: assert property (exc_valid && !exception_level_flag |=>
    s_q.fault == $past(exc_vaddr))
    else $error("fault address not captured");
  // fault held while exception level set
  fault_hold_a: assert property (!(exc_valid && !exception_level_flag) |=>
    $stable(s_q.fault))
    else $error("fault address changed under exception level");
  // two quiet cycles advance the counter by exactly one
  count_rate_a: assert property ((!wr_count ##1 !wr_count) |=>
    s_q.count == $past(s_q.count, 2) + COUNT_STEP)
    else $error("counter rate wrong");
  // match value write clears pending unless a match holds
  match_clear_a: assert property (wr_match |=>
    irq_pending_field[TIMER_IRQ_BIT] == $past(match_hit))
    else $error("timer pending not cleared by match write");
  // equality raises pending bit 7
  timer_set_a: assert property (match_hit |=> irq_pending_field[TIMER_IRQ_BIT])
    else $error("timer pending not set on match");
  // enabled masked pending gives a take one cycle later
  irq_take_a: assert property (irq_global_enable && |(irq_mask_field & irq_pending_field)
    |=> irq_take)
    else $error("pending interrupt not taken");
  // take needs the global enable
  irq_gate_a: assert property (!irq_global_enable |=> !irq_take)
    else $error("interrupt taken while disabled");
  // entry high reserved bits read zero in the wide layout
  ehi_zero_a: assert property (reg_rd_en && reg_num == REG_EHI && kernel_wide_addr |=>
    reg_rd_data[61:40] == 22'h0 && reg_rd_data[EHI_ZERO_HI:EHI_ZERO_LO] == 5'h0)
    else $error("entry high reserved bits not zero");
  // match value stable without a write
  match_stable_a: assert property (!wr_match |=> $stable(s_q.match))
    else $error("match value changed on its own");
  // victim index stays inside the array
  victim_range_a: assert property (tlb_victim_index <= TLB_TOP)
    else $error("victim index beyond the array");
  // victim steps down by one while above the boundary
  victim_step_a: assert property (!wr_pinned && s_q.victim > s_q.pinned &&
    s_q.victim <= TLB_TOP |=> s_q.victim == $past(s_q.victim) - 6'h01)
    else $error("victim index did not step down");
  // a random write takes the victim shown in its cycle
  rand_value_a: assert property (tlb_write_rand_op && s_q.victim >= s_q.pinned |=>
    tlb_write_index == $past(s_q.victim))
    else $error("random write index not the victim");
  // boundary write stores the low six bits only
  pinned_store_a: assert property (wr_pinned |=>
    s_q.pinned == $past(reg_wr_data[PINNED_W-1:0]))
    else $error("boundary not stored");
  // boundary changes only by its own write
  pinned_hold_a: assert property (!wr_pinned |=> $stable(s_q.pinned))
    else $error("boundary changed without a write");
  // the fault register ignores counter writes
  fault_ignore_a: assert property (wr_count && !exc_valid |=> $stable(s_q.fault))
    else $error("fault address changed by a write");
  // wide layout shows the whole captured address
  fault_wide_a: assert property (reg_rd_en && reg_num == REG_FAULT && kernel_wide_addr |=>
    reg_rd_data == $past(s_q.fault))
    else $error("wide fault read wrong");
  // narrow layout sign-extends bit 31 of the captured address
  fault_narrow_a: assert property (reg_rd_en && reg_num == REG_FAULT && !kernel_wide_addr |=>
    reg_rd_data == {{32{$past(s_q.fault[31])}}, $past(s_q.fault[31:0])})
    else $error("narrow fault read wrong");
  // software write to the counter lands next cycle
  count_write_a: assert property (wr_count |=>
    s_q.count == $past(reg_wr_data[31:0]))
    else $error("counter write lost");
  // off-phase cycles leave the counter alone
  count_hold_a: assert property (!wr_count && !s_q.half |=> $stable(s_q.count))
    else $error("counter stepped off phase");
  // all ones steps back to zero, nothing else happens
  count_wrap_a: assert property (!wr_count && s_q.half && s_q.count == 32'hffff_ffff |=>
    s_q.count == 32'h0000_0000)
    else $error("counter did not wrap");
  // match value write lands next cycle
  match_write_a: assert property (wr_match |=>
    s_q.match == $past(reg_wr_data[31:0]))
    else $error("match value write lost");
  // match value readback in the low word, upper zero
  match_read_a: assert property (reg_rd_en && reg_num == REG_MATCH |=>
    reg_rd_data == {32'h0000_0000, $past(s_q.match)})
    else $error("match value read wrong");
  // timer pending holds until the match value is written
  timer_hold_a: assert property (irq_pending_field[TIMER_IRQ_BIT] && !wr_match |=>
    irq_pending_field[TIMER_IRQ_BIT])
    else $error("timer pending dropped on its own");
  // the other pending bits follow their input one cycle late
  other_pend_a: assert property (1'b1 |=> irq_pending_field[6:0] == $past(irq_other_pending))
    else $error("other pending bits not passed through");
  // nothing masked in means no request
  take_mask_a: assert property (!(|(irq_mask_field & irq_pending_field)) |=> !irq_take)
    else $error("interrupt taken with nothing masked in");
  // tlb exceptions load the space id
  ehi_space_a: assert property (exc_valid && exc_is_tlb |=>
    s_q.ehi[7:0] == $past(exc_space_id))
    else $error("space id not loaded on tlb exception");
  // wide layout copies the region bits of the failing address
  ehi_region_a: assert property (exc_valid && exc_is_tlb && kernel_wide_addr |=>
    s_q.ehi[63:62] == $past(exc_vaddr[63:62]))
    else $error("region code not loaded");
  // indexed read loads entry high, masked to the layout
  ehi_load_a: assert property (tlb_read_idx_op && !(exc_valid && exc_is_tlb) |=>
    s_q.ehi == $past(tlb_read_entry_high & ehi_mask))
    else $error("entry high not loaded by tlb read");
  // probe and indexed write only read entry high
  ehi_source_a: assert property ((tlb_probe_op || tlb_write_idx_op) && !tlb_read_idx_op &&
    !wr_ehi && !exc_valid |=> $stable(s_q.ehi))
    else $error("entry high changed by a source-only op");
  // software writes the space id when nothing outranks it
  ehi_write_a: assert property (wr_ehi && !tlb_read_idx_op && !(exc_valid && exc_is_tlb) |=>
    s_q.ehi[7:0] == $past(reg_wr_data[7:0]))
    else $error("space id write lost");
  // reserved bits 12:8 are never stored
  ehi_hole_a: assert property (s_q.ehi[EHI_ZERO_HI:EHI_ZERO_LO] == 5'h00)
    else $error("entry high reserved bits stored");
  // narrow layout: holes zero and upper word a sign extension
  ehi_narrow_a: assert property (reg_rd_en && reg_num == REG_EHI && !kernel_wide_addr |=>
    reg_rd_data[EHI_ZERO_HI:EHI_ZERO_LO] == 5'h00 &&
    reg_rd_data[63:32] == {32{reg_rd_data[31]}})
    else $error("narrow entry high read wrong");
  // the read port is quiet between requests
  rd_idle_a: assert property (!reg_rd_en |=> !reg_rd_valid && reg_rd_data == 64'h0)
    else $error("read port not quiet");

  // main scenarios
  timer_fire_c: cover property (match_hit ##1 irq_pending_field[TIMER_IRQ_BIT] ##[1:4] wr_match);
  tlb_fault_c: cover property (exc_valid && exc_is_tlb && !exception_level_flag);
  rand_write_c: cover property (wr_pinned ##[1:8] tlb_write_rand_op);
  // source-only tlb ops are seen at all
  tlb_source_c: cover property (tlb_probe_op ##[1:8] tlb_write_idx_op);
  // counter crosses all ones
  count_wrap_c: cover property (s_q.count == 32'hffff_ffff ##[1:2] s_q.count == 32'h0000_0000);
endmodule : stt_regs

// *** stt_tlb_model.sv ***
// tlb array model standing behind the random and indexed tlb operations
`timescale 1ns/1ps
module stt_tlb_model (
  input wire logic ref_clk,
  input wire logic tlb_write_rand_op,
  input wire logic [5:0] tlb_write_index,
  input wire logic [63:0] tlb_entry_high,
  input wire logic [5:0] sel_idx,
  input wire logic tlb_read_idx_op,
  output logic [63:0] tlb_read_entry_high
);
  logic [63:0] mem_q [0:63]; // entry high half of each entry
  logic wr_seen_q; // write index lands one cycle after the op
  // store once the registered write index is valid
  always_ff @(posedge ref_clk) begin
    wr_seen_q <= tlb_write_rand_op;
    if (wr_seen_q) begin
      mem_q[tlb_write_index] <= tlb_entry_high;
    end
  end
  // outside a read the bus shows the inverse, never a stale copy
  assign tlb_read_entry_high = tlb_read_idx_op ? mem_q[sel_idx] : ~mem_q[sel_idx];
endmodule : stt_tlb_model

// *** testbench.sv ***
// self-checking bench for the tlb and timer system-control registers
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  import stt_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, exc_valid = 1'b0, exc_is_tlb = 1'b0;
  logic exception_level_flag = 1'b0, kernel_wide_addr = 1'b1, irq_global_enable = 1'b0;
  logic tlb_probe_op = 1'b0, tlb_write_rand_op = 1'b0, tlb_write_idx_op = 1'b0;
  logic tlb_read_idx_op = 1'b0, reg_rd_valid, irq_take;
  logic [4:0] reg_num = 5'h00;
  logic [63:0] reg_wr_data = 64'h0, exc_vaddr = 64'h0, reg_rd_data, tlb_entry_high;
  logic [63:0] tlb_read_entry_high, va, got_e, ex;
  logic [7:0] irq_mask_field = 8'h00, exc_space_id = 8'h00, irq_pending_field, sid;
  logic [6:0] irq_other_pending = 7'h00;
  logic [5:0] tlb_victim_index, tlb_write_index, sel_idx = 6'h00;
  logic [63:0] exp_q [$]; // read results still owed
  int err_total = 0, check_count = 0, seed = 32'h2b06, n;
  stt_regs dut_u (.ref_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_num, .reg_wr_data,
    .reg_rd_data, .reg_rd_valid, .exception_level_flag, .kernel_wide_addr,
    .irq_global_enable, .irq_mask_field, .irq_other_pending, .exc_valid, .exc_is_tlb,
    .exc_vaddr, .exc_space_id, .tlb_probe_op, .tlb_write_rand_op, .tlb_write_idx_op,
    .tlb_read_idx_op, .tlb_read_entry_high, .tlb_entry_high, .tlb_victim_index,
    .tlb_write_index, .irq_pending_field, .irq_take);
  stt_tlb_model tlb_u (.ref_clk, .tlb_write_rand_op, .tlb_write_index, .tlb_entry_high,
    .sel_idx, .tlb_read_idx_op, .tlb_read_entry_high);
  // 25 mhz core clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // register write, one-cycle strobe
  task automatic wr(input logic [4:0] num, input logic [63:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_num = num;
    reg_wr_data = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask : wr
  // register read, expectation queued for the monitor
  task automatic rd(input logic [4:0] num, input logic [63:0] e);
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_num = num;
    exp_q.push_back(e);
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
  endtask : rd
  // one-cycle pulse on an event input
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask : pulse
  // verdict and end of run
  task complete_run;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // read data stands one cycle, so look every cycle
  always @(negedge ref_clk) begin
    if (reg_rd_valid === 1'b1) begin
      got_e = exp_q.pop_front();
      `CHK("rd_data", got_e, reg_rd_data)
    end
  end
  // hang guard, well past the expected run length
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) arst_n = 1'b1;
    rd(REG_PINNED, 64'h0);
    rd(REG_MATCH, 64'h0);
    wr(REG_EHI, '1);
    rd(REG_EHI, EHI_MASK_64);
    wr(REG_PINNED, 64'h0000_0000_0000_0005);
    `CHK("victim", TLB_TOP, tlb_victim_index)
    rd(REG_PINNED, 64'h5);
    // random writes sweep the whole victim range
    for (n = 0; n < 60; n++) begin
      pulse(tlb_write_rand_op);
      `CHK("rand_idx", 1'b1, tlb_write_index >= 6'h05)
    end
    sel_idx = tlb_write_index;
    va = {$random(seed), $random(seed)};
    sid = 8'($random(seed));
    exc_vaddr = va;
    exc_space_id = sid;
    exc_is_tlb = 1'b1;
    pulse(exc_valid);
    rd(REG_FAULT, va);
    `CHK("ehi_exc", (va & EHI_MASK_64 & ~64'hff) | {56'h0, sid}, tlb_entry_high)
    // narrow layout of the same two registers
    kernel_wide_addr = 1'b0;
    ex = (va & EHI_MASK_32 & ~64'hff) | {56'h0, sid};
    rd(REG_FAULT, {{32{va[31]}}, va[31:0]});
    rd(REG_EHI, {{32{ex[31]}}, ex[31:0]});
    kernel_wide_addr = 1'b1;
    // a fault while the level flag is set leaves the address alone
    exception_level_flag = 1'b1;
    exc_vaddr = ~va;
    pulse(exc_valid);
    rd(REG_FAULT, va);
    exception_level_flag = 1'b0;
    exc_is_tlb = 1'b0;
    pulse(tlb_read_idx_op);
    `CHK("ehi_rd", EHI_MASK_64, tlb_entry_high)
    pulse(tlb_probe_op);
    pulse(tlb_write_idx_op);
    `CHK("ehi_src", EHI_MASK_64, tlb_entry_high)
    // counter crosses all ones to reach the match value
    wr(REG_COUNT, 64'hffff_fff8);
    wr(REG_MATCH, 64'h2);
    `CHK("pend_clr", 1'b0, irq_pending_field[7])
    n = 0;
    while (irq_pending_field[7] !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("match_time", 1'b1, n >= 18 && n <= 21)
    irq_other_pending = 7'($random(seed));
    irq_global_enable = 1'b1;
    irq_mask_field = 8'h80;
    repeat (3) @(negedge ref_clk);
    `CHK("take_on", 1'b1, irq_take)
    `CHK("other", irq_other_pending, irq_pending_field[6:0])
    irq_mask_field = {1'b0, ~irq_other_pending};
    repeat (3) @(negedge ref_clk);
    `CHK("take_off", 1'b0, irq_take)
    wr(REG_MATCH, 64'h1234_5678);
    `CHK("pend_wr", 1'b0, irq_pending_field[7])
    rd(REG_MATCH, 64'h1234_5678);
    rd(5'h1f, 64'h0);
    // second reset in mid-run brings the registers back
    @(negedge ref_clk) arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    rd(REG_PINNED, 64'h0);
    rd(REG_MATCH, 64'h0);
    repeat (4) @(negedge ref_clk);
    `CHK("drain", 0, exp_q.size())
    complete_run();
  end
endmodule : testbench
